// ===== tb/ecs_mem_model.sv
/*
  External device enabled by the chip selects.
  Assumes: selects active high, sampled on the bus clock.
*/
`timescale 1ns/100ps
`default_nettype none

module ecs_mem_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // enables from the decoder
  input wire logic [3:0] sels,
  // length of the last enable window
  output logic [3:0] last_len
);
  logic [3:0] run;

  // a slow device needs the enable for the whole window, so measure it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run <= 4'h0;
      last_len <= 4'h0;
    end else if (sels != 4'h0) begin
      run <= run + 4'h1;
    end else if (run != 4'h0) begin
      last_len <= run;
      run <= 4'h0;
    end
  end
endmodule

`default_nettype wire

// ===== tb/ecs_monitor.sv
/*
  Port checker of the chip-select decoder.
  Assumes: bound to ecs_decoder, one clock, synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none

module ecs_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // access
  input wire logic access_start,
  input wire logic [15:0] cpu_addr,
  input wire logic internal_claim,
  input wire logic access_busy,
  input wire logic access_done,
  // control readback
  input wire logic [7:0] prog_ctrl,
  input wire logic [3:0] data_ctrl,
  input wire logic [3:0] extra_ctrl,
  // expansion side
  input wire logic [7:0] exp_addr_high,
  input wire logic top_expansion_line,
  input wire logic prog_select_low,
  input wire logic prog_select_high,
  input wire logic data_select,
  input wire logic extra_select
);
  logic [3:0] sels;
  logic taken;
  logic [2:0] cnt;

  // select vector and accepted start
  assign sels = {prog_select_low, prog_select_high, data_select, extra_select};
  assign taken = access_start && !access_busy;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////
  // cycles already spent in the access; a stuck access overflows it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !access_busy) cnt <= 3'h0;
    else cnt <= cnt + 3'h1;
  end

  ////////////////////////////////////////////////////////////
  a_one_select:
    assert property ($onehot0(sels)) else $error("two selects at once");
  a_idle_quiet:
    assert property (!access_busy |-> sels == 4'h0 && exp_addr_high == 8'hFF)
    else $error("select or page outside access");
  a_top_bit:
    assert property (top_expansion_line == exp_addr_high[7]) else $error("top line off");
  a_start_busy:
    assert property (taken |=> access_busy) else $error("start not taken");
  a_stretch_max:
    assert property (access_busy |-> cnt <= 3'h3) else $error("access too long");
  a_done_ends:
    assert property (access_done |=> !access_busy) else $error("busy after done");
  a_sel_hold:
    assert property (access_busy && !access_done |=> access_busy && $stable(sels)
      && $stable(exp_addr_high)) else $error("select dropped early");
  a_claim_none:
    assert property (taken && internal_claim |=> sels == 4'h0 && access_done)
    else $error("select on internal access");
  a_low_steer:
    assert property (taken |=> !prog_select_low || ($past(cpu_addr[15]) &&
      $past(prog_ctrl[1]) && (!$past(prog_ctrl[3]) || top_expansion_line)))
    else $error("low select out of place");
  a_high_steer:
    assert property (taken |=> !prog_select_high || ($past(prog_ctrl[0]) &&
      (!$past(prog_ctrl[3]) || ($past(cpu_addr[15]) && !top_expansion_line))))
    else $error("high select out of place");
  a_data_en:
    assert property (taken |=> !data_select || $past(data_ctrl[0]))
    else $error("data select disabled");
  a_extra_en:
    assert property (taken |=> !extra_select || $past(extra_ctrl[0]))
    else $error("extra select disabled");

  // main scenarios
  c_long_low: cover property (access_done && prog_select_low && cnt == 3'h3);
  c_high_done: cover property (access_done && prog_select_high);
  c_extra: cover property (extra_select);
endmodule

bind ecs_decoder ecs_monitor i_ecs_monitor (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .access_start(access_start),
  .cpu_addr(cpu_addr), .internal_claim(internal_claim), .access_busy(access_busy),
  .access_done(access_done), .prog_ctrl(prog_ctrl), .data_ctrl(data_ctrl),
  .extra_ctrl(extra_ctrl), .exp_addr_high(exp_addr_high),
  .top_expansion_line(top_expansion_line), .prog_select_low(prog_select_low),
  .prog_select_high(prog_select_high), .data_select(data_select),
  .extra_select(extra_select)
);

`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench of the chip-select decoder.
  Assumes: decoder and device model compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  logic sys_clk, sys_rst, access_start, internal_claim, access_busy, access_done;
  logic prog_window_enable, data_window_sel, extra_window_sel, top_expansion_line;
  logic [15:0] cpu_addr;
  logic [7:0] program_page_reg, data_page_reg, extra_page_reg, exp_addr_high;
  logic [4:0] register_space_base;
  logic prog_ctrl_write, data_ctrl_write, extra_ctrl_write;
  logic [7:0] prog_ctrl_wdata, prog_ctrl, m_prog;
  logic [3:0] data_ctrl_wdata, extra_ctrl_wdata, data_ctrl, extra_ctrl, m_data, m_extra;
  logic prog_select_low, prog_select_high, data_select, extra_select;
  logic [3:0] sel_vec, last_len;
  logic [31:0] r;
  int n_errors, total_checks, i;

  assign sel_vec = {prog_select_low, prog_select_high, data_select, extra_select};

  ecs_decoder i_ecs_decoder (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .access_start(access_start),
    .cpu_addr(cpu_addr), .internal_claim(internal_claim), .access_busy(access_busy),
    .access_done(access_done), .prog_window_enable(prog_window_enable),
    .data_window_sel(data_window_sel), .extra_window_sel(extra_window_sel),
    .program_page_reg(program_page_reg), .data_page_reg(data_page_reg),
    .extra_page_reg(extra_page_reg), .register_space_base(register_space_base),
    .prog_ctrl_write(prog_ctrl_write), .prog_ctrl_wdata(prog_ctrl_wdata),
    .data_ctrl_write(data_ctrl_write), .data_ctrl_wdata(data_ctrl_wdata),
    .extra_ctrl_write(extra_ctrl_write), .extra_ctrl_wdata(extra_ctrl_wdata),
    .prog_ctrl(prog_ctrl), .data_ctrl(data_ctrl), .extra_ctrl(extra_ctrl),
    .exp_addr_high(exp_addr_high), .top_expansion_line(top_expansion_line),
    .prog_select_low(prog_select_low), .prog_select_high(prog_select_high),
    .data_select(data_select), .extra_select(extra_select)
  );

  ecs_mem_model i_ecs_mem_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sels(sel_vec), .last_len(last_len)
  );

  ////////////////////////////////////////////////////////////
  // bus clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // a control write; readback shows it one cycle later
  task automatic wr(input int w, input logic [7:0] v);
    @(posedge sys_clk);
    prog_ctrl_write <= (w == 0);
    data_ctrl_write <= (w == 1);
    extra_ctrl_write <= (w == 2);
    prog_ctrl_wdata <= v;
    data_ctrl_wdata <= v[3:0];
    extra_ctrl_wdata <= v[3:0];
    @(posedge sys_clk);
    prog_ctrl_write <= 1'b0;
    data_ctrl_write <= 1'b0;
    extra_ctrl_write <= 1'b0;
    #1;
    if (w == 0) m_prog = v;
    else if (w == 1) m_data = v[3:0];
    else m_extra = v[3:0];
    `CHK({prog_ctrl, data_ctrl, extra_ctrl}, {m_prog, m_data, m_extra})
  endtask

  // reference decode of the sampled inputs; priority extra, data, low, high
  task automatic model(output logic [3:0] es, output logic [7:0] eh, output int st);
    logic pw, up, top, lo, hi, da, ex;
    pw = prog_window_enable && cpu_addr >= 16'h8000 && cpu_addr <= 16'hBFFF;
    eh = pw ? program_page_reg : extra_window_sel ? extra_page_reg :
      data_window_sel ? data_page_reg : {6'h3F, cpu_addr[15:14]};
    up = cpu_addr[15];
    top = eh[7];
    lo = m_prog[1] && up && (!m_prog[3] || top);
    hi = m_prog[0] && (m_prog[3] ? up && !top : m_prog[2] || up);
    da = m_data[0] && (m_data[1] ? !up : data_window_sel);
    ex = m_extra[0] && (m_extra[1] ? extra_window_sel :
      cpu_addr[15:11] == register_space_base);
    es = 4'h0;
    st = 0;
    if (internal_claim) es = 4'h0;
    else if (ex) {es, st} = {4'h1, 30'h0, m_extra[3:2]};
    else if (da) {es, st} = {4'h2, 30'h0, m_data[3:2]};
    else if (lo) {es, st} = {4'h8, 30'h0, m_prog[5:4]};
    else if (hi) {es, st} = {4'h4, 30'h0, m_prog[7:6]};
  endtask

  // one access; dup repeats the start while busy, which must be ignored
  task automatic acc(input logic [15:0] a, input logic dup);
    logic [3:0] es;
    logic [7:0] eh;
    int st, n;
    r = $urandom;
    @(posedge sys_clk);
    access_start <= 1'b1;
    cpu_addr <= a;
    internal_claim <= (r[7:5] == 3'h0);
    {prog_window_enable, data_window_sel, extra_window_sel} <= r[4:2];
    register_space_base <= r[0] ? a[15:11] : r[12:8];
    {program_page_reg, data_page_reg, extra_page_reg} <= {r[31:16], r[15:8]};
    @(posedge sys_clk);
    model(es, eh, st);
    access_start <= dup;
    cpu_addr <= ~a;
    for (n = 1; n <= 6; n++) begin
      #1;
      `CHK({sel_vec, exp_addr_high, access_busy}, {es, eh, 1'b1})
      `CHK(top_expansion_line, eh[7])
      if (access_done === 1'b1) break;
      @(posedge sys_clk);
      access_start <= 1'b0;
    end
    `CHK(n, st + 1)
    @(posedge sys_clk);
    access_start <= 1'b0;
    #1;
    `CHK({sel_vec, exp_addr_high, access_busy}, {4'h0, 8'hFF, 1'b0})
    `CHK(top_expansion_line, 1'b1)
    @(posedge sys_clk);
    #1;
    if (es != 4'h0) `CHK(last_len, st[3:0] + 4'h1)
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {access_start, internal_claim, prog_window_enable, data_window_sel} = 4'h0;
    {extra_window_sel, prog_ctrl_write, data_ctrl_write, extra_ctrl_write} = 4'h0;
    {cpu_addr, program_page_reg, data_page_reg, extra_page_reg} = 40'h0;
    {register_space_base, prog_ctrl_wdata, data_ctrl_wdata, extra_ctrl_wdata} = 21'h0;
    {m_prog, m_data, m_extra} = 16'h0200;
    n_errors = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    r = $urandom(37372);
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({prog_ctrl, data_ctrl, extra_ctrl, sel_vec}, 20'h02000)
    `CHK(exp_addr_high, 8'hFF)
    acc(16'hC000, 1'b0);
    acc(16'h1000, 1'b1);
    for (i = 0; i < 300; i++) begin
      r = $urandom;
      if (r[1:0] == 2'h0) wr(int'(r[3:2]) % 3, r[15:8]);
      r = $urandom;
      case (r[2:0])
        3'h0: acc(16'h7FFF, r[3]);
        3'h1: acc(16'h8000, r[3]);
        3'h2: acc(16'hBFFF, r[3]);
        3'h3: acc(16'hC000, r[3]);
        default: acc(r[31:16], r[3]);
      endcase
    end
    // reset again mid-run: every written control value must fall back
    wr(0, 8'hFD);
    wr(1, 8'h0F);
    wr(2, 8'h0F);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    {m_prog, m_data, m_extra} = 16'h0200;
    #1;
    `CHK({prog_ctrl, data_ctrl, extra_ctrl, sel_vec}, 20'h02000)
    acc(16'hFFFE, 1'b0);
    end_sim();
  end

  // watchdog against a hung access
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end
endmodule

`default_nettype wire

// ===== verilog/ecs_decoder.sv
/*
  Expansion chip-select decoder: two program selects, a data select and an
  extra select, each with enable, region option and 0..3 stretch cycles,
  plus the high expansion address lines.
  Assumes: one access at a time, started by a one-cycle access_start with
  the cpu address and window select lines valid in that cycle; inputs are
  synchronous to sys_clk.
*/
// Function
// - two program selects, eight control bits
// - high program select enable, reset off
// - low program select enable, reset on
// - full-map bit widens high select region
// - high program select has lowest priority
// - steering picks select by top line
// - steering ignores full map, upper half only
// - no steering: top line ignored
// - low program stretch adds 0..3 cycles
// - high program stretch adds 0..3 cycles
// - low select covers $8000 to $FFFF
// - steering splits pages between program selects
// - data select enable, reset off
// - half-map bit picks lower half region
// - data stretch adds 0..3 cycles
// - extra select enable, reset off
// - follow bit picks page or register area
// - extra stretch adds 0..3 cycles
// - decode uses address and window lines
// - program window is $8000 to $BFFF
// - matching enabled select asserts its output
// - window page on high lines, else six ones above cpu A15..A14
`include "ecs_params.svh"
`timescale 1ns/100ps
`default_nettype none

module ecs_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // cpu access request
  input wire logic access_start,
  input wire logic [15:0] cpu_addr,
  input wire logic internal_claim,
  output logic access_busy,
  output logic access_done,
  // overlay window select lines and page registers
  input wire logic prog_window_enable,
  input wire logic data_window_sel,
  input wire logic extra_window_sel,
  input wire logic [7:0] program_page_reg,
  input wire logic [7:0] data_page_reg,
  input wire logic [7:0] extra_page_reg,
  input wire logic [4:0] register_space_base,
  // control writes
  input wire logic prog_ctrl_write,
  input wire logic [7:0] prog_ctrl_wdata,
  input wire logic data_ctrl_write,
  input wire logic [3:0] data_ctrl_wdata,
  input wire logic extra_ctrl_write,
  input wire logic [3:0] extra_ctrl_wdata,
  // control readback
  output logic [7:0] prog_ctrl,
  output logic [3:0] data_ctrl,
  output logic [3:0] extra_ctrl,
  // expansion address lines
  output logic [7:0] exp_addr_high,
  output logic top_expansion_line,
  // chip selects, active high
  output logic prog_select_low,
  output logic prog_select_high,
  output logic data_select,
  output logic extra_select
);

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  ecs_pkg::ecs_state_t state;
  ecs_pkg::ecs_state_t next_state;
  ecs_pkg::ecs_sel_t winner;
  ecs_pkg::ecs_sel_t active_sel;

  // program control byte; low select comes up enabled so boot memory works
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_ctrl <= `ECS_PROG_RESET;
    end else if (prog_ctrl_write) begin
      prog_ctrl <= prog_ctrl_wdata;
    end
  end

  // data control nibble, disabled after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_ctrl <= `ECS_DATA_RESET;
    end else if (data_ctrl_write) begin
      data_ctrl <= data_ctrl_wdata;
    end
  end

  // extra control nibble, disabled after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      extra_ctrl <= `ECS_EXTRA_RESET;
    end else if (extra_ctrl_write) begin
      extra_ctrl <= extra_ctrl_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control field breakout

  logic high_en;
  logic low_en;
  logic full_map_bit;
  logic top_address_steering;
  logic [1:0] prog_low_stretch;
  logic [1:0] prog_high_stretch;
  logic data_select_enable;
  logic data_half_map;
  logic [1:0] data_stretch;
  logic extra_select_enable;
  logic extra_page_follow;
  logic [1:0] extra_stretch;

  // named views of the three control registers
  assign high_en = prog_ctrl[`ECS_P_HIGH_EN];
  assign low_en = prog_ctrl[`ECS_P_LOW_EN];
  assign full_map_bit = prog_ctrl[`ECS_P_FULL_MAP];
  assign top_address_steering = prog_ctrl[`ECS_P_STEER];
  assign prog_low_stretch = prog_ctrl[`ECS_P_LOW_STR_HI:`ECS_P_LOW_STR_LO];
  assign prog_high_stretch = prog_ctrl[`ECS_P_HIGH_STR_HI:`ECS_P_HIGH_STR_LO];
  assign data_select_enable = data_ctrl[`ECS_Q_EN];
  assign data_half_map = data_ctrl[`ECS_Q_MODE];
  assign data_stretch = data_ctrl[`ECS_Q_STR_HI:`ECS_Q_STR_LO];
  assign extra_select_enable = extra_ctrl[`ECS_Q_EN];
  assign extra_page_follow = extra_ctrl[`ECS_Q_MODE];
  assign extra_stretch = extra_ctrl[`ECS_Q_STR_HI:`ECS_Q_STR_LO];

  ////////////////////////////////////////////////////////////////////////////
  // address range matches

  logic in_prog_window_range;
  logic in_upper;
  logic in_lower;
  logic in_prog_window;
  logic in_reg_area;

  // the 16 Kbyte program overlay window
  ecs_range_match #(
    .LO(`ECS_PROG_WIN_LO),
    .HI(`ECS_PROG_WIN_HI)
  ) u_prog_win (
    .addr(cpu_addr),
    .hit(in_prog_window_range)
  );

  // upper half, where the low program select lives, and the high one unless full map widens it
  ecs_range_match #(
    .LO(`ECS_UPPER_LO),
    .HI(`ECS_UPPER_HI)
  ) u_upper (
    .addr(cpu_addr),
    .hit(in_upper)
  );

  // lower half, for the data select half-map option
  ecs_range_match #(
    .LO(`ECS_LOWER_LO),
    .HI(`ECS_LOWER_HI)
  ) u_lower (
    .addr(cpu_addr),
    .hit(in_lower)
  );

  // the window only counts as paged while the window select line is on
  assign in_prog_window = prog_window_enable && in_prog_window_range;

  // register space area sits on any 2 Kbyte boundary
  assign in_reg_area =
    (cpu_addr[`ECS_REG_AREA_MSB:`ECS_REG_AREA_LSB] == register_space_base);

  ////////////////////////////////////////////////////////////////////////////
  // expansion address translation

  logic [7:0] next_addr_high;
  logic top_line_now;

  // page onto the high lines inside a window; unpaged drives the top ones high
  always_comb begin
    if (in_prog_window) begin
      next_addr_high = program_page_reg;
    end else if (extra_window_sel) begin
      next_addr_high = extra_page_reg;
    end else if (data_window_sel) begin
      next_addr_high = data_page_reg;
    end else begin
      next_addr_high = {`ECS_UNPAGED_HIGH, cpu_addr[15:14]};
    end
  end

  // top expansion line as it will appear for this access
  assign top_line_now = next_addr_high[`ECS_PAGE_TOP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // per-select region matches

  logic low_match;
  logic high_match;
  logic data_match;
  logic extra_match;

  // low program select: whole upper half; with steering only top line high
  always_comb begin
    if (top_address_steering) begin
      low_match = low_en && in_upper && top_line_now;
    end else begin
      low_match = low_en && in_upper;
    end
  end

  // high program select: full map ignored under steering
  always_comb begin
    if (top_address_steering) begin
      high_match = high_en && in_upper && !top_line_now;
    end else if (full_map_bit) begin
      high_match = high_en;
    end else begin
      high_match = high_en && in_upper;
    end
  end

  // data select: lower half or the data window
  always_comb begin
    if (data_half_map) begin
      data_match = data_select_enable && in_lower;
    end else begin
      data_match = data_select_enable && data_window_sel;
    end
  end

  // extra select: extra page window or register space area
  always_comb begin
    if (extra_page_follow) begin
      extra_match = extra_select_enable && extra_window_sel;
    end else begin
      extra_match = extra_select_enable && in_reg_area;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority

  // internal resources first, the high program select always last; a miss
  // everywhere is plain external space with no select at all
  always_comb begin
    if (internal_claim) begin
      winner = ecs_pkg::ECS_SEL_NONE;
    end else if (extra_match) begin
      winner = ecs_pkg::ECS_SEL_EXTRA;
    end else if (data_match) begin
      winner = ecs_pkg::ECS_SEL_DATA;
    end else if (low_match) begin
      winner = ecs_pkg::ECS_SEL_PLOW;
    end else if (high_match) begin
      winner = ecs_pkg::ECS_SEL_PHIGH;
    end else begin
      winner = ecs_pkg::ECS_SEL_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stretch selection

  logic [1:0] next_stretch;

  // the winner's own stretch field; unselected accesses are never stretched
  always_comb begin
    case (winner)
      ecs_pkg::ECS_SEL_PLOW: next_stretch = prog_low_stretch;
      ecs_pkg::ECS_SEL_PHIGH: next_stretch = prog_high_stretch;
      ecs_pkg::ECS_SEL_DATA: next_stretch = data_stretch;
      ecs_pkg::ECS_SEL_EXTRA: next_stretch = extra_stretch;
      default: next_stretch = `ECS_STRETCH_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer

  logic start_ok;
  logic expired;

  // a start during a running access is ignored; the cpu sees access_busy
  assign start_ok = access_start && (state == ecs_pkg::ECS_IDLE);

  ecs_stretch_timer u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(start_ok),
    .stretch(next_stretch),
    .expired(expired)
  );

  // one base cycle plus the loaded stretch cycles
  always_comb begin
    case (state)
      ecs_pkg::ECS_IDLE: begin
        next_state = start_ok ? ecs_pkg::ECS_ACCESS : ecs_pkg::ECS_IDLE;
      end
      ecs_pkg::ECS_ACCESS: begin
        next_state = expired ? ecs_pkg::ECS_IDLE : ecs_pkg::ECS_ACCESS;
      end
      default: next_state = ecs_pkg::ECS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ecs_pkg::ECS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // handshake outputs are combinational
  assign access_busy = (state == ecs_pkg::ECS_ACCESS);
  assign access_done = (state == ecs_pkg::ECS_ACCESS) && expired;

  ////////////////////////////////////////////////////////////////////////////
  // latched decode result

  // control writes during an access do not disturb it: the winner is held
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      active_sel <= ecs_pkg::ECS_SEL_NONE;
    end else if (start_ok) begin
      active_sel <= winner;
    end else if (access_done) begin
      active_sel <= ecs_pkg::ECS_SEL_NONE;
    end
  end

  // chip select outputs from flops, one-hot, held over the stretch
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_select_low <= 1'b0;
      prog_select_high <= 1'b0;
      data_select <= 1'b0;
      extra_select <= 1'b0;
    end else if (start_ok) begin
      prog_select_low <= (winner == ecs_pkg::ECS_SEL_PLOW);
      prog_select_high <= (winner == ecs_pkg::ECS_SEL_PHIGH);
      data_select <= (winner == ecs_pkg::ECS_SEL_DATA);
      extra_select <= (winner == ecs_pkg::ECS_SEL_EXTRA);
    end else if (access_done) begin
      prog_select_low <= 1'b0;
      prog_select_high <= 1'b0;
      data_select <= 1'b0;
      extra_select <= 1'b0;
    end
  end

  // high address lines held for the access, all ones between accesses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      exp_addr_high <= `ECS_IDLE_ADDR_HIGH;
    end else if (start_ok) begin
      exp_addr_high <= next_addr_high;
    end else if (access_done) begin
      exp_addr_high <= `ECS_IDLE_ADDR_HIGH;
    end
  end

  // top line is the highest of the translated lines
  assign top_expansion_line = exp_addr_high[`ECS_PAGE_TOP_BIT];

endmodule

`default_nettype wire

// ===== verilog/ecs_params.svh
/*
  Constants of the expansion chip-select decoder: control field positions,
  reset values and address ranges.
  Assumes: included by bare name from the decoder and stretch timer files.
*/
`ifndef ECS_PARAMS_SVH
`define ECS_PARAMS_SVH

// program control byte layout
`define ECS_P_HIGH_EN 0
`define ECS_P_LOW_EN 1
`define ECS_P_FULL_MAP 2
`define ECS_P_STEER 3
`define ECS_P_LOW_STR_LO 4
`define ECS_P_LOW_STR_HI 5
`define ECS_P_HIGH_STR_LO 6
`define ECS_P_HIGH_STR_HI 7
// low program select enabled, all else off
`define ECS_PROG_RESET 8'h02

// data and extra control nibble layout
`define ECS_Q_EN 0
`define ECS_Q_MODE 1
`define ECS_Q_STR_LO 2
`define ECS_Q_STR_HI 3
`define ECS_DATA_RESET 4'h0
`define ECS_EXTRA_RESET 4'h0

// address ranges
`define ECS_PROG_WIN_LO 16'h8000
`define ECS_PROG_WIN_HI 16'hBFFF
`define ECS_UPPER_LO 16'h8000
`define ECS_UPPER_HI 16'hFFFF
`define ECS_LOWER_LO 16'h0000
`define ECS_LOWER_HI 16'h7FFF
// register space area is 2 Kbyte aligned: compare address bits 15..11
`define ECS_REG_AREA_MSB 15
`define ECS_REG_AREA_LSB 11

// expansion address pins above the 14 low cpu lines, top six driven high when unpaged
`define ECS_UNPAGED_HIGH 6'h3F
`define ECS_IDLE_ADDR_HIGH 8'hFF
`define ECS_PAGE_TOP_BIT 7
`define ECS_STRETCH_NONE 2'h0

`endif

// ===== verilog/ecs_pkg.sv
/*
  Types of the expansion chip-select decoder.
  Assumes: nothing beyond the parameter header.
*/
package ecs_pkg;

  // access sequencer states
  typedef enum logic [0:0] {
    ECS_IDLE = 1'b0,
    ECS_ACCESS = 1'b1
  } ecs_state_t;

  // which select won the decode
  typedef enum logic [2:0] {
    ECS_SEL_NONE = 3'h0,
    ECS_SEL_PLOW = 3'h1,
    ECS_SEL_PHIGH = 3'h2,
    ECS_SEL_DATA = 3'h3,
    ECS_SEL_EXTRA = 3'h4
  } ecs_sel_t;

endpackage

// ===== verilog/ecs_range_match.sv
/*
  Inclusive address range comparator.
  Assumes: combinational use on a 16-bit cpu address.
*/
`timescale 1ns/100ps
`default_nettype none

module ecs_range_match #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
) (
  // address in
  input wire logic [15:0] addr,
  // match out
  output logic hit
);

  // both bounds inclusive
  assign hit = (addr >= LO) && (addr <= HI);

endmodule

`default_nettype wire

// ===== verilog/ecs_stretch_timer.sv
/*
  Down counter that times the extra E-cycles of one stretched access.
  Assumes: load is a one-cycle pulse at access start.
*/
`include "ecs_params.svh"
`timescale 1ns/100ps
`default_nettype none

module ecs_stretch_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // load
  input wire logic load,
  input wire logic [1:0] stretch,
  // status
  output logic expired
);

  logic [1:0] count;

  // count down to zero after load, hold at zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= `ECS_STRETCH_NONE;
    end else if (load) begin
      count <= stretch;
    end else if (count != `ECS_STRETCH_NONE) begin
      count <= count - 2'h1;
    end
  end

  assign expired = (count == `ECS_STRETCH_NONE);

endmodule

`default_nettype wire
